//--- prcg_regs.svh
`ifndef PRCG_REGS_SVH
`define PRCG_REGS_SVH
`define PRCG_OFF_APB2_RST   8'h0C
`define PRCG_OFF_APB1_RST   8'h10
`define PRCG_OFF_AHB_EN     8'h14
`define PRCG_OFF_APB2_EN    8'h18
`define PRCG_RST_APB2_RST   32'h0000_0000
`define PRCG_RST_APB1_RST   32'h0000_0000
`define PRCG_RST_AHB_EN     32'h0000_0014
`define PRCG_RST_APB2_EN    32'h0000_0000
`define PRCG_MSK_APB2_RST   32'hC030_7E03
`define PRCG_MSK_APB1_RST   32'h3866_4831
`define PRCG_MSK_AHB_EN     32'h007E_405F
`define PRCG_MSK_APB2_EN    32'hE030_7E03
`define PRCG_BIT_SYSCFG     0
`define PRCG_BIT_DAC        29
`define PRCG_BIT_PMU        28
`define PRCG_BIT_BKP        27
`define PRCG_BIT_TW_SECOND  22
`define PRCG_BIT_TW_FIRST   21
`define PRCG_BIT_SER_THIRD  18
`define PRCG_BIT_SER_SECOND 17
`define PRCG_BIT_SPI_SECOND 14
`define PRCG_BIT_WWDG       11
`define PRCG_BIT_TMR_SIX    5
`define PRCG_BIT_TMR_FIVE   4
`define PRCG_BIT_TMR_ONE    0
`define PRCG_BIT_GPIO_A     17
`define PRCG_GPIO_PORTS     6
`define PRCG_BIT_MFCOM      14
`define PRCG_BIT_CRC        6
`define PRCG_BIT_FLASH_SP   4
`define PRCG_BIT_DMAMUX     3
`define PRCG_BIT_SRAM_SP    2
`define PRCG_BIT_DMA_SECOND 1
`define PRCG_BIT_DMA_FIRST  0
`define PRCG_RESP_OKAY      2'h0
`define PRCG_RESP_SLVERR    2'h2
`endif

//--- prcg_pkg.sv
package prcg_pkg;
	typedef enum logic [1:0] {
		PRCG_IDLE,
		PRCG_RESP
	} prcg_phase_t;
endpackage

//--- prcg_clock_gate.sv
`timescale 1ns/1ps
module prcg_clock_gate (
	input  wire logic clock_i,
	input  wire logic reset_i,
	input  wire logic enable_i,
	output logic      gated_clock_o
);
	typedef struct packed {
		logic en_latch;
	} prcg_gate_state_t;
	prcg_gate_state_t st;
	prcg_gate_state_t next_st;
	// enable only changes while clock is low, so no runt pulses
	always_comb begin
		next_st          = st;
		next_st.en_latch = enable_i;
	end
	always_ff @(negedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign gated_clock_o = clock_i & st.en_latch;
endmodule

//--- prcg_gate_bank.sv
`timescale 1ns/1ps
module prcg_gate_bank #(
	parameter int N = 12
) (
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	input  wire logic [N-1:0] enable_i,
	output logic      [N-1:0] gated_clock_o
);
	// refused at elaboration: an empty bank has nothing to gate
	if (N < 1) begin : g_bad_n
		$error("gate bank needs at least one gate");
	end
	for (genvar g = 0; g < N; g++) begin : g_gate
		prcg_clock_gate u_gate (
			.clock_i      (clock_i),
			.reset_i      (reset_i),
			.enable_i     (enable_i[g]),
			.gated_clock_o(gated_clock_o[g])
		);
	end
endmodule

//--- prcg_reset_clock_ctrl.sv
`timescale 1ns/1ps
`include "prcg_regs.svh"
module prcg_reset_clock_ctrl
	import prcg_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        sleep_mode_i,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             sysconfig_reset_o,
	output logic             dac_reset_o,
	output logic             power_ctrl_reset_o,
	output logic             backup_ctrl_reset_o,
	output logic             twowire_first_reset_o,
	output logic             twowire_second_reset_o,
	output logic             serial_second_reset_o,
	output logic             serial_third_reset_o,
	output logic             spi_second_reset_o,
	output logic             window_watchdog_reset_o,
	output logic             basic_timer_five_reset_o,
	output logic             basic_timer_six_reset_o,
	output logic             gp_timer_one_reset_o,
	output logic [5:0]       gpio_port_clock_o,
	output logic             multifunction_comm_clock_o,
	output logic             checksum_unit_clock_o,
	output logic             flash_ctrl_clock_o,
	output logic             dma_request_mux_clock_o,
	output logic             sram_clock_o,
	output logic             dma_second_clock_o,
	output logic             dma_first_clock_o
);
	localparam int NGATE = 12;

	typedef struct packed {
		logic [31:0] apb2_peripheral_reset;
		logic [31:0] apb1_peripheral_reset;
		logic [31:0] ahb_clock_enable;
		logic [31:0] apb2_clock_enable;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		prcg_phase_t wr_phase;
		logic [1:0]  bresp;
		prcg_phase_t rd_phase;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [12:0] resets;
	} prcg_state_t;

	prcg_state_t st;
	prcg_state_t next_st;
	logic [NGATE-1:0] gate_en;
	logic [NGATE-1:0] gate_clk;
	logic             sleep_s1;
	logic             sleep_s2;

	// sleep request may come from another domain, so two stages first
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
		end else begin
			sleep_s1 <= sleep_mode_i;
			sleep_s2 <= sleep_s1;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		// reserved bits are kept at reset value even if software slips
		merge = res & mask;
	endfunction

	always_comb begin
		logic [31:0] apb2r;
		logic [31:0] apb1r;
		next_st = st;
		apb2r   = st.apb2_peripheral_reset;
		apb1r   = st.apb1_peripheral_reset;
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		case (st.wr_phase)
			PRCG_IDLE: begin
				if (st.aw_held && st.w_held) begin
					next_st.aw_held  = 1'b0;
					next_st.w_held   = 1'b0;
					next_st.wr_phase = PRCG_RESP;
					next_st.bresp    = `PRCG_RESP_OKAY;
					case ({2'b00, st.aw_addr[7:2]})
						`PRCG_OFF_APB2_RST >> 2: begin
							next_st.apb2_peripheral_reset = merge(
								apb2r, st.w_data, st.w_strb,
								`PRCG_MSK_APB2_RST);
						end
						`PRCG_OFF_APB1_RST >> 2: begin
							next_st.apb1_peripheral_reset = merge(
								apb1r, st.w_data, st.w_strb,
								`PRCG_MSK_APB1_RST);
						end
						`PRCG_OFF_AHB_EN >> 2: begin
							next_st.ahb_clock_enable = merge(
								st.ahb_clock_enable, st.w_data,
								st.w_strb, `PRCG_MSK_AHB_EN);
						end
						`PRCG_OFF_APB2_EN >> 2: begin
							next_st.apb2_clock_enable = merge(
								st.apb2_clock_enable, st.w_data,
								st.w_strb, `PRCG_MSK_APB2_EN);
						end
						default: begin
							next_st.bresp = `PRCG_RESP_SLVERR;
						end
					endcase
				end
			end
			PRCG_RESP: begin
				if (s_axi_bready) begin
					next_st.wr_phase = PRCG_IDLE;
				end
			end
			default: begin
				next_st.wr_phase = PRCG_IDLE;
			end
		endcase
		case (st.rd_phase)
			PRCG_IDLE: begin
				if (s_axi_arvalid) begin
					next_st.rd_phase = PRCG_RESP;
					next_st.rresp    = `PRCG_RESP_OKAY;
					case ({2'b00, s_axi_araddr[7:2]})
						`PRCG_OFF_APB2_RST >> 2:
							next_st.rdata = st.apb2_peripheral_reset;
						`PRCG_OFF_APB1_RST >> 2:
							next_st.rdata = st.apb1_peripheral_reset;
						`PRCG_OFF_AHB_EN >> 2:
							next_st.rdata = st.ahb_clock_enable;
						`PRCG_OFF_APB2_EN >> 2:
							next_st.rdata = st.apb2_clock_enable;
						default: begin
							next_st.rdata = 32'h0000_0000;
							next_st.rresp = `PRCG_RESP_SLVERR;
						end
					endcase
				end
			end
			PRCG_RESP: begin
				if (s_axi_rready) begin
					next_st.rd_phase = PRCG_IDLE;
				end
			end
			default: begin
				next_st.rd_phase = PRCG_IDLE;
			end
		endcase
		// reset lines are registered on the same edge as the register bits, glitch free
		apb2r = next_st.apb2_peripheral_reset;
		apb1r = next_st.apb1_peripheral_reset;
		next_st.resets = {
			apb2r[`PRCG_BIT_SYSCFG],
			apb1r[`PRCG_BIT_DAC],
			apb1r[`PRCG_BIT_PMU],
			apb1r[`PRCG_BIT_BKP],
			apb1r[`PRCG_BIT_TW_FIRST],
			apb1r[`PRCG_BIT_TW_SECOND],
			apb1r[`PRCG_BIT_SER_SECOND],
			apb1r[`PRCG_BIT_SER_THIRD],
			apb1r[`PRCG_BIT_SPI_SECOND],
			apb1r[`PRCG_BIT_WWDG],
			apb1r[`PRCG_BIT_TMR_FIVE],
			apb1r[`PRCG_BIT_TMR_SIX],
			apb1r[`PRCG_BIT_TMR_ONE]
		};
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			st                       <= '0;
			st.apb2_peripheral_reset <= `PRCG_RST_APB2_RST;
			st.apb1_peripheral_reset <= `PRCG_RST_APB1_RST;
			st.ahb_clock_enable      <= `PRCG_RST_AHB_EN;
			st.apb2_clock_enable     <= `PRCG_RST_APB2_EN;
			st.wr_phase              <= PRCG_IDLE;
			st.rd_phase              <= PRCG_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = !st.aw_held;
	assign s_axi_wready  = !st.w_held;
	assign s_axi_bvalid  = (st.wr_phase == PRCG_RESP);
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = (st.rd_phase == PRCG_IDLE);
	assign s_axi_rvalid  = (st.rd_phase == PRCG_RESP);
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	assign {sysconfig_reset_o, dac_reset_o, power_ctrl_reset_o,
		backup_ctrl_reset_o, twowire_first_reset_o, twowire_second_reset_o,
		serial_second_reset_o, serial_third_reset_o, spi_second_reset_o,
		window_watchdog_reset_o, basic_timer_five_reset_o,
		basic_timer_six_reset_o, gp_timer_one_reset_o} = st.resets;

	// PRCG_BIT_FLASH_SP and PRCG_BIT_SRAM_SP are sleep-only bits: those clocks always run while awake
	always_comb begin
		gate_en[5:0] = st.ahb_clock_enable[`PRCG_BIT_GPIO_A +:
			`PRCG_GPIO_PORTS];
		gate_en[6]   = st.ahb_clock_enable[`PRCG_BIT_MFCOM];
		gate_en[7]   = st.ahb_clock_enable[`PRCG_BIT_CRC];
		gate_en[8]   = !sleep_s2 ||
			st.ahb_clock_enable[`PRCG_BIT_FLASH_SP];
		gate_en[9]   = st.ahb_clock_enable[`PRCG_BIT_DMAMUX];
		gate_en[10]  = !sleep_s2 ||
			st.ahb_clock_enable[`PRCG_BIT_SRAM_SP];
		gate_en[11]  = st.ahb_clock_enable[`PRCG_BIT_DMA_SECOND];
	end

	prcg_gate_bank #(
		.N(NGATE)
	) u_bank (
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.enable_i     (gate_en),
		.gated_clock_o(gate_clk)
	);

	prcg_clock_gate u_dma_first (
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.enable_i     (st.ahb_clock_enable[`PRCG_BIT_DMA_FIRST]),
		.gated_clock_o(dma_first_clock_o)
	);

	assign gpio_port_clock_o          = gate_clk[5:0];
	assign multifunction_comm_clock_o = gate_clk[6];
	assign checksum_unit_clock_o      = gate_clk[7];
	assign flash_ctrl_clock_o         = gate_clk[8];
	assign dma_request_mux_clock_o    = gate_clk[9];
	assign sram_clock_o               = gate_clk[10];
	assign dma_second_clock_o         = gate_clk[11];
endmodule

//--- prcg_props.sv
`timescale 1ns/1ps
module prcg_props (
	input wire logic        clock_i,
	input wire logic        reset_i,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        dac_reset_o,
	input wire logic        gp_timer_one_reset_o,
	input wire logic [5:0]  gpio_port_clock_o,
	input wire logic        dma_first_clock_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& !s_axi_bvalid;
	endsequence
	sequence b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_b_hold: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_dac_change: assert property ($changed(dac_reset_o) |->
		$rose(s_axi_bvalid)) else $error("dac reset moved without write");
	chk_timer_change: assert property ($changed(gp_timer_one_reset_o) |->
		$rose(s_axi_bvalid)) else $error("timer reset moved without write");
	// gated clocks must be low at every rising edge, else a runt pulse
	chk_gate_low: assert property (!dma_first_clock_o &&
		gpio_port_clock_o == 6'h00) else $error("gated clock high before edge");
endmodule
bind prcg_reset_clock_ctrl prcg_props u_props (.clock_i(clock_i),
	.reset_i(reset_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .dac_reset_o(dac_reset_o),
	.gp_timer_one_reset_o(gp_timer_one_reset_o),
	.gpio_port_clock_o(gpio_port_clock_o),
	.dma_first_clock_o(dma_first_clock_o));

//--- tb.sv
`timescale 1ns/1ps
`include "prcg_regs.svh"
module tb;
	logic        clock_i, reset_i, sleep_mode_i;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [11:0] rst_vec;
	logic [12:0] gclk;
	logic        sys_rst;
	int          errors, tests_run, i;
	int          bits[12] = '{29, 28, 27, 22, 21, 18, 17, 14, 11, 5, 4, 0};
	logic [31:0] pat[4] = '{32'h0, 32'h007E405F, 32'h00540049, 32'h002A0016};
	prcg_reset_clock_ctrl u_dut (.clock_i(clock_i), .reset_i(reset_i),
		.sleep_mode_i(sleep_mode_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sysconfig_reset_o(sys_rst),
		.dac_reset_o(rst_vec[11]), .power_ctrl_reset_o(rst_vec[10]),
		.backup_ctrl_reset_o(rst_vec[9]), .twowire_second_reset_o(rst_vec[8]),
		.twowire_first_reset_o(rst_vec[7]), .serial_third_reset_o(rst_vec[6]),
		.serial_second_reset_o(rst_vec[5]), .spi_second_reset_o(rst_vec[4]),
		.window_watchdog_reset_o(rst_vec[3]),
		.basic_timer_six_reset_o(rst_vec[2]),
		.basic_timer_five_reset_o(rst_vec[1]),
		.gp_timer_one_reset_o(rst_vec[0]), .gpio_port_clock_o(gclk[12:7]),
		.multifunction_comm_clock_o(gclk[6]), .checksum_unit_clock_o(gclk[5]),
		.flash_ctrl_clock_o(gclk[4]), .dma_request_mux_clock_o(gclk[3]),
		.sram_clock_o(gclk[2]), .dma_second_clock_o(gclk[1]),
		.dma_first_clock_o(gclk[0]));
	function automatic logic [11:0] rst_exp(input logic [31:0] m);
		for (int k = 0; k < 12; k++) rst_exp[11-k] = m[bits[k]];
	endfunction
	function automatic logic [12:0] gexp(input logic [31:0] e, input logic s);
		return {e[22:17], e[14], e[6], !s | e[4], e[3], !s | e[2], e[1], e[0]};
	endfunction
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bready raised only after bvalid, so the slave must hold its answer
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge clock_i);
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1;
		while (!(aw && w)) begin
			@(negedge clock_i);
			if (awvalid && awready) aw = 1;
			if (wvalid && wready) w = 1;
			@(posedge clock_i);
			if (aw) awvalid <= 0;
			if (w) wvalid <= 0;
		end
		do @(negedge clock_i); while (!bvalid);
		@(posedge clock_i) bready <= 1;
		@(posedge clock_i) bready <= 0;
		rs = bresp;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clock_i);
		araddr <= a; arvalid <= 1;
		do @(negedge clock_i); while (!arready);
		@(posedge clock_i) arvalid <= 0;
		do @(negedge clock_i); while (!rvalid);
		@(posedge clock_i) rready <= 1;
		// data taken at the edge that sees rready high
		@(posedge clock_i) rready <= 0;
		rd = rdata;
		rs = rresp;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk_word(rd, e);
	endtask
	task gate_chk(input logic [31:0] e);
		wr(`PRCG_OFF_AHB_EN, e, 4'hF);
		repeat (3) @(posedge clock_i);
		#1 chk_word({19'h0, gclk}, {19'h0, gexp(e, sleep_mode_i)});
	endtask
	task t_regs;
		rd_chk(`PRCG_OFF_APB2_RST, `PRCG_RST_APB2_RST);
		rd_chk(`PRCG_OFF_APB1_RST, `PRCG_RST_APB1_RST);
		rd_chk(`PRCG_OFF_AHB_EN, `PRCG_RST_AHB_EN);
		rd_chk(`PRCG_OFF_APB2_EN, `PRCG_RST_APB2_EN);
		rd_chk(8'h20, 32'h0);
		chk_resp(rs, `PRCG_RESP_SLVERR);
		wr(8'h20, 32'hFFFFFFFF, 4'hF);
		chk_resp(rs, `PRCG_RESP_SLVERR);
		wr(`PRCG_OFF_APB2_EN, `PRCG_MSK_APB2_EN, 4'hF);
		rd_chk(`PRCG_OFF_APB2_EN, `PRCG_MSK_APB2_EN);
		chk_resp(rs, `PRCG_RESP_OKAY);
		$display("reset values done");
	endtask
	task t_apb1;
		wr(`PRCG_OFF_APB1_RST, `PRCG_MSK_APB1_RST, 4'hF);
		rd_chk(`PRCG_OFF_APB1_RST, `PRCG_MSK_APB1_RST);
		chk_word(rst_vec, 12'hFFF);
		for (i = 0; i < 12; i++) begin
			wr(`PRCG_OFF_APB1_RST, 32'h1 << bits[i], 4'hF);
			chk_resp(rs, `PRCG_RESP_OKAY);
			chk_word(rst_vec, rst_exp(32'h1 << bits[i]));
		end
		wr(`PRCG_OFF_APB1_RST, `PRCG_MSK_APB1_RST, 4'h2);
		rd_chk(`PRCG_OFF_APB1_RST, 32'h00004801);
		chk_word(rst_vec, rst_exp(32'h00004801));
		wr(`PRCG_OFF_APB1_RST, 32'h0, 4'hF);
		chk_word(rst_vec, 12'h0);
		$display("peripheral resets done");
	endtask
	task t_sys;
		wr(`PRCG_OFF_APB2_RST, 32'h1, 4'hF);
		chk_word(sys_rst, 1'b1);
		wr(`PRCG_OFF_APB2_RST, 32'h0, 4'hF);
		chk_word(sys_rst, 1'b0);
		$display("sysconfig reset done");
	endtask
	task t_gates;
		for (i = 0; i < 4; i++) gate_chk(pat[i]);
		$display("clock gates done");
	endtask
	task t_sleep;
		@(posedge clock_i) sleep_mode_i <= 1;
		gate_chk(32'h10);
		gate_chk(32'h04);
		gate_chk(32'h0);
		@(posedge clock_i) sleep_mode_i <= 0;
		gate_chk(32'h0);
		$display("sleep clocks done");
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clock_i = 0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		reset_i = 1; sleep_mode_i = 0; awaddr = 0; araddr = 0; wdata = 0;
		wstrb = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
		rready = 0; errors = 0; tests_run = 0;
		repeat (6) @(posedge clock_i);
		reset_i <= 0;
		t_regs;
		t_apb1;
		t_sys;
		t_gates;
		t_sleep;
		close_out;
	end
	// a few hundred cycles expected, generous margin
	initial begin
		#40000;
		errors++;
		close_out;
	end
endmodule
